/* logic/npe_pkg.sv */
// Shared constants for the NAND page code result registers, segments four to eight
package npe_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int NPE_ADDR_W = 32;
  localparam int NPE_DATA_W = 32;
  localparam logic [31:0] NPE_SEG4_ADDR = 32'hffffe820;
  localparam logic [31:0] NPE_SEG5_ADDR = 32'hffffe824;
  localparam logic [31:0] NPE_SEG6_ADDR = 32'hffffe828;
  localparam logic [31:0] NPE_SEG7_ADDR = 32'hffffe82c;
  localparam logic [31:0] NPE_SEG8_ADDR = 32'hffffe830;
  localparam logic [31:0] NPE_STAT_ADDR = 32'hffffe8f0;
  localparam logic [31:0] NPE_MASK_ADDR = 32'hffffe8f4;
  localparam logic [31:0] NPE_READ_IDLE = 32'h00000000;

  // ----------------------------------------------------------------
  // Page layout
  // ----------------------------------------------------------------
  localparam int NPE_NUM_SEG = 5;
  localparam int NPE_PAGE_AW = 12;
  localparam logic [11:0] NPE_FIRST_BYTE = 12'h400;
  localparam logic [11:0] NPE_LAST_BYTE = 12'h8ff;
  localparam int NPE_SEG_SHIFT = 8;
  localparam logic [3:0] NPE_FIRST_SEG = 4'h4;

  // ----------------------------------------------------------------
  // Field layout of each result word
  // ----------------------------------------------------------------
  localparam int NPE_BIT_W = 3;
  localparam int NPE_WORD_W = 8;
  localparam int NPE_CHK_W = 11;
  localparam int NPE_BIT_LSB = 0;
  localparam int NPE_WORD_LSB = 3;
  localparam int NPE_CHK_LSB = 12;

  // ----------------------------------------------------------------
  // Status and mask layout, and result field reset values
  // ----------------------------------------------------------------
  localparam int NPE_FLAG_W = 13;
  localparam int NPE_SINGLE_LSB = 0;
  localparam int NPE_MULTI_LSB = 8;
  localparam logic [12:0] NPE_FLAG_RST = 13'h0000;
  localparam logic [2:0] NPE_BIT_RST = 3'h0;
  localparam logic [7:0] NPE_WORD_RST = 8'h00;
  localparam logic [10:0] NPE_CHK_RST = 11'h000;

endpackage : npe_pkg

/* logic/npe_sticky.sv */
// Sticky event flags, cleared by writing one, where a set beats a clear
module npe_sticky
  import npe_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clr,
  output logic [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // An event in the clearing cycle must survive
  assign flags_next = (flags_reg & ~clr) | set;

  always_ff @(posedge clock) begin
    if (srst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule : npe_sticky

/* logic/npe_seg_slot.sv */
// One segment's result register: bit offset, word address and check bits
module npe_seg_slot
  import npe_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic load,
  input wire logic [2:0] bit_in,
  input wire logic [7:0] word_in,
  input wire logic [10:0] chk_in,
  output logic [31:0] image
);

  logic [2:0] bad_bit_pos_reg;
  logic [7:0] bad_word_pos_reg;
  logic [10:0] inv_check_bits_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      bad_bit_pos_reg <= NPE_BIT_RST;
      bad_word_pos_reg <= NPE_WORD_RST;
      inv_check_bits_reg <= NPE_CHK_RST;
    end else if (load) begin
      bad_bit_pos_reg <= bit_in;
      bad_word_pos_reg <= word_in;
      inv_check_bits_reg <= chk_in;
    end
  end

  // Gaps and the upper byte stay zero
  always_comb begin
    image = '0;
    image[NPE_BIT_LSB +: NPE_BIT_W] = bad_bit_pos_reg;
    image[NPE_WORD_LSB +: NPE_WORD_W] = bad_word_pos_reg;
    image[NPE_CHK_LSB +: NPE_CHK_W] = inv_check_bits_reg;
  end

endmodule : npe_seg_slot

/* logic/npe_result_regs.sv */
// Result registers of the page code unit for page segments four to eight
//
// The implementer's own choice: the strobed register port.
module npe_result_regs
  import npe_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic res_valid,
  input wire logic [11:0] res_byte_addr,
  input wire logic [2:0] res_bit,
  input wire logic [10:0] res_check_bits,
  input wire logic res_single,
  input wire logic res_multi,
  output logic irq
);

  // ----------------------------------------------------------------
  // Segment selection
  // ----------------------------------------------------------------
  logic in_range;
  logic [3:0] seg_num;
  logic [2:0] seg_idx;
  logic [4:0] seg_load;
  logic [31:0] slot_word [NPE_NUM_SEG];

  // Bytes outside this part of the page belong to other registers
  assign in_range = (res_byte_addr >= NPE_FIRST_BYTE) && (res_byte_addr <= NPE_LAST_BYTE);
  assign seg_num = res_byte_addr[NPE_PAGE_AW-1:NPE_SEG_SHIFT];
  assign seg_idx = 3'(seg_num - NPE_FIRST_SEG);

  always_comb begin
    seg_load = '0;
    if (res_valid && in_range) begin
      seg_load[seg_idx] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Result slots
  // ----------------------------------------------------------------
  // The offsets are taken as delivered even for several errors; only the
  // multi flag tells software that they are not usable.
  genvar gi;
  generate
    for (gi = 0; gi < NPE_NUM_SEG; gi++) begin : g_slot
      npe_seg_slot u_slot (
        .clock(clock),
        .srst(srst),
        .load(seg_load[gi]),
        .bit_in(res_bit),
        .word_in(res_byte_addr[NPE_WORD_W-1:0]),
        .chk_in(res_check_bits),
        .image(slot_word[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Event flags and interrupt
  // ----------------------------------------------------------------
  logic [12:0] flag_set;
  logic [12:0] flag_clr;
  logic [12:0] flag_now;
  logic [12:0] mask_reg;
  logic stat_wr;
  logic mask_wr;

  assign stat_wr = reg_wr && (reg_addr == NPE_STAT_ADDR);
  assign mask_wr = reg_wr && (reg_addr == NPE_MASK_ADDR);

  always_comb begin
    flag_set = '0;
    if (res_single) begin
      flag_set[NPE_SINGLE_LSB +: NPE_NUM_SEG] = seg_load;
    end
    if (res_multi) begin
      flag_set[NPE_MULTI_LSB +: NPE_NUM_SEG] = seg_load;
    end
  end

  assign flag_clr = stat_wr ? reg_wdata[NPE_FLAG_W-1:0] : '0;

  npe_sticky #(
    .WIDTH(NPE_FLAG_W)
  ) u_flags (
    .clock(clock),
    .srst(srst),
    .set(flag_set),
    .clr(flag_clr),
    .flags(flag_now)
  );

  always_ff @(posedge clock) begin
    if (srst) begin
      mask_reg <= NPE_FLAG_RST;
    end else if (mask_wr) begin
      mask_reg <= reg_wdata[NPE_FLAG_W-1:0];
    end
  end

  assign irq = |(flag_now & mask_reg);

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Writes to result words fall through: nothing decodes them
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = NPE_READ_IDLE;
    if (reg_rd) begin
      unique case (reg_addr)
        NPE_SEG4_ADDR: rdata_next = slot_word[0];
        NPE_SEG5_ADDR: rdata_next = slot_word[1];
        NPE_SEG6_ADDR: rdata_next = slot_word[2];
        NPE_SEG7_ADDR: rdata_next = slot_word[3];
        NPE_SEG8_ADDR: rdata_next = slot_word[4];
        NPE_STAT_ADDR: rdata_next = 32'(flag_now);
        NPE_MASK_ADDR: rdata_next = 32'(mask_reg);
        default: rdata_next = NPE_READ_IDLE;
      endcase
    end
  end

  // Data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_reg <= NPE_READ_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_bit_pos;
    @(posedge clock) disable iff (srst)
    (res_valid && in_range && res_single) |=>
      (slot_word[$past(seg_idx)][2:0] == $past(res_bit));
  endproperty
  a_bit_pos: assert property (p_bit_pos)
    else $error("bit offset not captured");

  property p_word_pos;
    @(posedge clock) disable iff (srst)
    (res_valid && in_range && res_single) |=>
      (slot_word[$past(seg_idx)][10:3] == $past(res_byte_addr[7:0]));
  endproperty
  a_word_pos: assert property (p_word_pos)
    else $error("word address not captured");

  property p_multi_flag;
    @(posedge clock) disable iff (srst)
    (res_valid && in_range && res_multi) |=>
      flag_now[NPE_MULTI_LSB + 32'($past(seg_idx))];
  endproperty
  a_multi_flag: assert property (p_multi_flag)
    else $error("multiple error not flagged");

  property p_out_of_range;
    @(posedge clock) disable iff (srst)
    (res_valid && !in_range) |=>
      ($stable(slot_word[0]) && $stable(slot_word[2]) && $stable(slot_word[4]));
  endproperty
  a_out_of_range: assert property (p_out_of_range)
    else $error("foreign byte changed a segment");

  property p_seg6_read;
    @(posedge clock) disable iff (srst)
    (reg_rd && reg_addr == NPE_SEG6_ADDR) |=> (reg_rdata == $past(slot_word[2]));
  endproperty
  a_seg6_read: assert property (p_seg6_read)
    else $error("segment six read wrong");

  property p_read_only;
    @(posedge clock) disable iff (srst)
    (reg_wr && !res_valid) |=> ($stable(slot_word[1]) && $stable(slot_word[3]));
  endproperty
  a_read_only: assert property (p_read_only)
    else $error("bus write changed a result");

  property p_zero_bits;
    @(posedge clock) disable iff (srst)
    $past(reg_rd) && ($past(reg_addr) == NPE_SEG8_ADDR) |->
      (reg_rdata[31:23] == 9'h000) && !reg_rdata[11];
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("reserved bits not zero");

  property p_irq_level;
    @(posedge clock) disable iff (srst)
    (res_valid && in_range && res_single && !mask_wr &&
      mask_reg[NPE_SINGLE_LSB + 32'(seg_idx)]) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt missing");

  property p_chk_bits;
    @(posedge clock) disable iff (srst)
    (res_valid && in_range) |=>
      (slot_word[$past(seg_idx)][NPE_CHK_LSB +: NPE_CHK_W] == $past(res_check_bits));
  endproperty
  a_chk_bits: assert property (p_chk_bits)
    else $error("check bits not captured");

  property p_single_flag;
    @(posedge clock) disable iff (srst)
    (res_valid && in_range && res_single) |=>
      flag_now[NPE_SINGLE_LSB + 32'($past(seg_idx))];
  endproperty
  a_single_flag: assert property (p_single_flag)
    else $error("single error not flagged");

  property p_foreign_flags;
    @(posedge clock) disable iff (srst)
    (res_valid && !in_range) |=>
      ((flag_now & ~$past(flag_now)) == NPE_FLAG_RST);
  endproperty
  a_foreign_flags: assert property (p_foreign_flags)
    else $error("foreign byte raised a flag");

  property p_foreign_odd;
    @(posedge clock) disable iff (srst)
    (res_valid && !in_range) |=> ($stable(slot_word[1]) && $stable(slot_word[3]));
  endproperty
  a_foreign_odd: assert property (p_foreign_odd)
    else $error("foreign byte changed an odd segment");

  property p_read_only_even;
    @(posedge clock) disable iff (srst)
    (reg_wr && !res_valid) |=>
      ($stable(slot_word[0]) && $stable(slot_word[2]) && $stable(slot_word[4]));
  endproperty
  a_read_only_even: assert property (p_read_only_even)
    else $error("bus write changed an even result");

  // ----------------------------------------------------------------
  // Read port, flag and reset assertions
  // ----------------------------------------------------------------
  // Each word is checked on its own so a decode slip names the segment
  property p_seg4_read;
    @(posedge clock) disable iff (srst)
    (reg_rd && reg_addr == NPE_SEG4_ADDR) |=> (reg_rdata == $past(slot_word[0]));
  endproperty
  a_seg4_read: assert property (p_seg4_read)
    else $error("segment four read wrong");

  property p_seg5_read;
    @(posedge clock) disable iff (srst)
    (reg_rd && reg_addr == NPE_SEG5_ADDR) |=> (reg_rdata == $past(slot_word[1]));
  endproperty
  a_seg5_read: assert property (p_seg5_read)
    else $error("segment five read wrong");

  property p_seg7_read;
    @(posedge clock) disable iff (srst)
    (reg_rd && reg_addr == NPE_SEG7_ADDR) |=> (reg_rdata == $past(slot_word[3]));
  endproperty
  a_seg7_read: assert property (p_seg7_read)
    else $error("segment seven read wrong");

  property p_seg8_read;
    @(posedge clock) disable iff (srst)
    (reg_rd && reg_addr == NPE_SEG8_ADDR) |=> (reg_rdata == $past(slot_word[4]));
  endproperty
  a_seg8_read: assert property (p_seg8_read)
    else $error("segment eight read wrong");

  property p_stat_read;
    @(posedge clock) disable iff (srst)
    (reg_rd && reg_addr == NPE_STAT_ADDR) |=> (reg_rdata == 32'($past(flag_now)));
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("status read wrong");

  property p_mask_read;
    @(posedge clock) disable iff (srst)
    (reg_rd && reg_addr == NPE_MASK_ADDR) |=> (reg_rdata == 32'($past(mask_reg)));
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask read wrong");

  // Software may poll without a strobe; stale words must not linger
  property p_read_idle;
    @(posedge clock) disable iff (srst)
    !$past(reg_rd) |-> (reg_rdata == NPE_READ_IDLE);
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data outside its cycle");

  property p_mask_write;
    @(posedge clock) disable iff (srst)
    mask_wr |=> (mask_reg == $past(reg_wdata[NPE_FLAG_W-1:0]));
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write lost");

  property p_clear;
    @(posedge clock) disable iff (srst)
    (stat_wr && (flag_set == NPE_FLAG_RST)) |=> ((flag_now & $past(flag_clr)) == NPE_FLAG_RST);
  endproperty
  a_clear: assert property (p_clear)
    else $error("status flag not cleared");

  // A clear racing an event must not hide that event from software
  property p_set_wins;
    @(posedge clock) disable iff (srst)
    (|(flag_set & flag_clr)) |=>
      ((flag_now & $past(flag_set)) == $past(flag_set));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost to a clear");

  property p_reset_clean;
    @(posedge clock) disable iff (srst)
    $past(srst) |->
      (slot_word[0] == '0) && (slot_word[1] == '0) && (slot_word[2] == '0) &&
      (slot_word[3] == '0) && (slot_word[4] == '0) && (flag_now == NPE_FLAG_RST) &&
      (mask_reg == NPE_FLAG_RST) && !irq && (reg_rdata == NPE_READ_IDLE);
  endproperty
  a_reset_clean: assert property (p_reset_clean)
    else $error("state not cleared by reset");

  c_single: cover property (@(posedge clock) disable iff (srst)
    res_valid && in_range && res_single ##[1:8] reg_rd ##1 reg_rdata != NPE_READ_IDLE);
  c_multi: cover property (@(posedge clock) disable iff (srst)
    res_valid && in_range && res_multi);
  c_irq_clear: cover property (@(posedge clock) disable iff (srst)
    irq ##1 stat_wr ##1 !irq);
  c_set_wins: cover property (@(posedge clock) disable iff (srst)
    |(flag_set & flag_clr));

endmodule : npe_result_regs

/* test/npe_page_src.sv */
// Model of the page reader that hands one segment result at a time to the registers
module npe_page_src
  import npe_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic go,
  input wire logic [11:0] g_addr,
  input wire logic [2:0] g_bit,
  input wire logic [10:0] g_chk,
  input wire logic g_single,
  input wire logic g_multi,
  output logic res_valid,
  output logic [11:0] res_byte_addr,
  output logic [2:0] res_bit,
  output logic [10:0] res_check_bits,
  output logic res_single,
  output logic res_multi
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Result pulse
  // ----------------------------------------------------------------
  // Between results res_valid stays low and every other output toggles, so stale values never pass for data
  always_ff @(posedge clock) begin
    if (srst) begin
      res_valid <= 1'b0;
      res_byte_addr <= 12'h000;
      res_bit <= 3'h0;
      res_check_bits <= 11'h000;
      res_single <= 1'b0;
      res_multi <= 1'b0;
    end else if (go) begin
      res_valid <= 1'b1;
      res_byte_addr <= g_addr;
      res_bit <= g_bit;
      res_check_bits <= g_chk;
      res_single <= g_single;
      res_multi <= g_multi;
    end else begin
      res_valid <= 1'b0;
      res_byte_addr <= ~res_byte_addr;
      res_bit <= ~res_bit;
      res_check_bits <= ~res_check_bits;
      res_single <= ~res_single;
      res_multi <= ~res_multi;
    end
  end
endmodule : npe_page_src

/* test/npe_result_regs_tb.sv */
// Self-checking bench for the segment four to eight result registers
module npe_result_regs_tb
  import npe_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals and tasks
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq;
  logic go = 1'b0;
  logic [11:0] g_addr = 12'h0;
  logic [2:0] g_bit = 3'h0;
  logic [10:0] g_chk = 11'h0;
  logic g_single = 1'b0;
  logic g_multi = 1'b0;
  logic res_valid, res_single, res_multi;
  logic [11:0] res_byte_addr;
  logic [2:0] res_bit;
  logic [10:0] res_check_bits;
  logic [7:0] wd;
  logic [31:0] exp_w [5];
  int n_mismatch = 0;
  int n_compared = 0;

  always #25 clock = ~clock;

  npe_result_regs i_dut (.clock(clock), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .res_valid(res_valid), .res_byte_addr(res_byte_addr), .res_bit(res_bit),
    .res_check_bits(res_check_bits), .res_single(res_single), .res_multi(res_multi),
    .irq(irq));

  npe_page_src i_src (.clock(clock), .srst(srst), .go(go), .g_addr(g_addr), .g_bit(g_bit),
    .g_chk(g_chk), .g_single(g_single), .g_multi(g_multi), .res_valid(res_valid),
    .res_byte_addr(res_byte_addr), .res_bit(res_bit), .res_check_bits(res_check_bits),
    .res_single(res_single), .res_multi(res_multi));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : check

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask : rdchk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // One result from the reader; returns once the registers have taken it
  task automatic send(input logic [11:0] a, input logic [2:0] b, input logic [10:0] c,
                      input logic m);
    @(posedge clock);
    go <= 1'b1;
    g_addr <= a;
    g_bit <= b;
    g_chk <= c;
    g_single <= ~m;
    g_multi <= m;
    @(posedge clock);
    go <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : send

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++) rdchk(NPE_SEG4_ADDR + 32'(4 * i), 32'h0);
    rdchk(NPE_STAT_ADDR, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("test reset_values done");
    // Segment edges 0x400 and 0x8ff included; writes to results must not stick
    for (int s = 0; s < 5; s++) begin
      wd = (s == 4) ? 8'hff : 8'(8'h30 * s);
      exp_w[s] = {9'h0, 11'(11'h5a3 ^ s), 1'b0, wd, 3'(s + 3)};
      send(12'h400 + 12'(s * 256) + 12'(wd), 3'(s + 3), 11'(11'h5a3 ^ s), 1'b0);
      wr(NPE_SEG4_ADDR + 32'(4 * s), 32'hffffffff);
    end
    for (int s = 0; s < 5; s++) rdchk(NPE_SEG4_ADDR + 32'(4 * s), exp_w[s]);
    @(posedge clock);
    #1 check(reg_rdata, 32'h0);
    rdchk(NPE_STAT_ADDR, 32'h1f);
    $display("test single_error done");
    wr(NPE_STAT_ADDR, 32'h1fff);
    rdchk(NPE_STAT_ADDR, 32'h0);
    send(12'h3ff, 3'h7, 11'h7ff, 1'b0);
    send(12'h900, 3'h7, 11'h7ff, 1'b0);
    rdchk(NPE_SEG4_ADDR, exp_w[0]);
    rdchk(NPE_SEG8_ADDR, exp_w[4]);
    rdchk(NPE_STAT_ADDR, 32'h0);
    $display("test out_of_range done");
    wr(NPE_MASK_ADDR, 32'h100);
    rdchk(NPE_MASK_ADDR, 32'h100);
    send(12'h6c4, 3'h1, 11'h00f, 1'b1);
    rdchk(NPE_STAT_ADDR, 32'h400);
    check({31'h0, irq}, 32'h0);
    send(12'h410, 3'h2, 11'h0f0, 1'b1);
    rdchk(NPE_STAT_ADDR, 32'h500);
    check({31'h0, irq}, 32'h1);
    wr(NPE_STAT_ADDR, 32'h100);
    rdchk(NPE_STAT_ADDR, 32'h400);
    check({31'h0, irq}, 32'h0);
    rdchk(32'hffffe834, 32'h0);
    wr(32'hffffe834, 32'hffffffff);
    rdchk(NPE_MASK_ADDR, 32'h100);
    $display("test multi_error_irq done");
    // Segment eight single error through its own mask bit
    wr(NPE_MASK_ADDR, 32'h10);
    send(12'h8a5, 3'h4, 11'h123, 1'b0);
    rdchk(NPE_SEG8_ADDR, {9'h0, 11'h123, 1'b0, 8'ha5, 3'h4});
    rdchk(NPE_STAT_ADDR, 32'h410);
    check({31'h0, irq}, 32'h1);
    $display("test single_irq done");
    // Reset in mid-run must clear results, flags and mask
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    rdchk(NPE_SEG8_ADDR, 32'h0);
    rdchk(NPE_MASK_ADDR, 32'h0);
    rdchk(NPE_STAT_ADDR, 32'h0);
    check({31'h0, irq}, 32'h0);
    // Clear and event for one flag on the same edge: the event survives
    fork
      send(12'h5e1, 3'h6, 11'h2aa, 1'b0);
      begin
        @(posedge clock);
        wr(NPE_STAT_ADDR, 32'h2);
      end
    join
    rdchk(NPE_STAT_ADDR, 32'h2);
    rdchk(NPE_SEG5_ADDR, {9'h0, 11'h2aa, 1'b0, 8'he1, 3'h6});
    $display("test reset_and_set_wins done");
    close_out();
  end

  // Guard against a hang anywhere in the sequence
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    close_out();
  end
endmodule : npe_result_regs_tb
